// file: verilog/plh_link_handshake.sv
/*
 * Command and data output handshake between a controller and the link words.
 * Assumes the controller holds its words stable while its requests stand,
 * and that file work is done by a job engine behind job_start/job_done.
 */
// Functional notes
// R1 - Command 5000/0070 saves active system and scene group zero data to a file.
// R2 - Requester puts save path at +4 onward, at most 256 characters.
// R3 - Response echoes command at +2/+3, code at +4, result 0 or FFFFFFFF at +5.
// R4 - Command 6010/0070 captures screen, forcing .bmp when another extension given.
// R5 - All-zero argument from +4 makes capture use the default folder.
// R6 - Requester loads command and argument before raising execute request.
// R7 - Accepted execute request raises busy and starts the command.
// R8 - Response words are written before the completion flag rises.
// R9 - Requester drops execute request only after seeing completion flag.
// R10 - Execute request drop clears completion flag and busy.
// R11 - Execute held past retry interval after completion forces flag and busy low.
// R12 - Requester raises output request to ask for data.
// R13 - Device presents output data, then raises output strobe.
// R14 - Requester captures data after strobe, then drops output request.
// R15 - Strobe clears after request drops; next request after next measurement.
// R16 - No output request within retry interval drops strobe and discards data.
// R17 - Output request held past retry interval drops strobe and ends output.
// R18 - No host answer within overtime raises the error output.
// R19 - Output number format selectable as fixed or floating point.
// R20 - Execute requests are ignored while busy until the handshake is idle.
`timescale 1ns/1ps
`include "plh_defs.svh"
`default_nettype none
module plh_link_handshake #(
   parameter int CYC_PER_MS = `PLH_CYC_PER_MS,
   parameter int DATA_W     = 32
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic [15:0]          command_code,
   input  wire logic [15:0]          command_subcode,
   input  wire logic [31:0]          command_argument,
   input  wire logic                 execute_request,
   output logic                      busy,
   output logic                      completion_flag,
   output logic [15:0]               resp_command_code,
   output logic [15:0]               resp_command_subcode,
   output logic [15:0]               result_code,
   output logic [31:0]               result_payload,
   output plh_pkg::plh_action_t      job_action,
   output logic                      job_append_bmp,
   output logic                      job_start,
   input  wire logic                 job_done,
   input  wire logic                 job_ok,
   input  wire logic [19:0]          retry_ms,
   input  wire logic                 format_float,
   input  wire logic                 meas_valid,
   output logic                      meas_ready,
   input  wire logic [DATA_W-1:0]    meas_fixed,
   input  wire logic [DATA_W-1:0]    meas_float,
   input  wire logic                 output_request,
   output logic                      output_strobe,
   output logic [DATA_W-1:0]         output_data,
   output logic                      overtime_error,
   input  wire logic                 error_clear
);
   import plh_pkg::*;

   // -----------------------------------------------------------------
   // Command handshake
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      PLH_C_IDLE,
      PLH_C_RUN,
      PLH_C_DONE,
      PLH_C_HOLD
   } plh_cmd_state_t;

   plh_cmd_state_t cstate;
   plh_action_t    next_action;
   logic           next_bmp;
   logic           cmd_tmo;
   logic           known;
   logic           resp_ready;

   initial begin
      if (DATA_W < 1) $error("DATA_W must be at least one.");
      if (CYC_PER_MS < 1) $error("CYC_PER_MS must be at least one.");
   end

   assign known = (command_subcode == `PLH_CMD_SUBCODE);

   always_comb begin
      next_action = PLH_ACT_NONE;
      next_bmp    = 1'b0;
      if (known && command_code == `PLH_CMD_SAVE_ALL) begin
         next_action = PLH_ACT_SAVE_ALL;                           // [R1]
      end else if (known && command_code == `PLH_CMD_SCREEN_CAP) begin
         if (command_argument == 32'h0) begin
            next_action = PLH_ACT_CAPTURE_DEFAULT;                  // [R5]
         end else begin
            next_action = PLH_ACT_CAPTURE;
            next_bmp    = (command_argument != `PLH_EXT_BMP);       // [R4]
         end
      end
   end

   plh_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_cmd_timer (
      .clk      (clk),
      .rst_n    (rst_n),
      .run      (cstate == PLH_C_DONE),
      .limit_ms (retry_ms),
      .expired  (cmd_tmo)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cstate         <= PLH_C_IDLE;
         busy           <= 1'b0;
         completion_flag <= 1'b0;
         job_start      <= 1'b0;
         job_action     <= PLH_ACT_NONE;
         job_append_bmp <= 1'b0;
      end else begin
         job_start <= 1'b0;
         case (cstate)
            PLH_C_IDLE: begin
               if (execute_request) begin
                  busy           <= 1'b1;                           // [R7]
                  job_action     <= next_action;
                  job_append_bmp <= next_bmp;
                  job_start      <= (next_action != PLH_ACT_NONE);
                  cstate         <= PLH_C_RUN;
               end
            end
            PLH_C_RUN: begin
               if (resp_ready) begin
                  completion_flag <= 1'b1;                          // [R8]
                  cstate          <= PLH_C_DONE;
               end
            end
            PLH_C_DONE: begin
               if (!execute_request || cmd_tmo) begin
                  completion_flag <= 1'b0;                          // [R10] [R11]
                  busy            <= 1'b0;
                  cstate <= execute_request ? PLH_C_HOLD : PLH_C_IDLE;
               end
            end
            PLH_C_HOLD: begin
               if (!execute_request) cstate <= PLH_C_IDLE;          // [R20]
            end
            default: cstate <= PLH_C_IDLE;
         endcase
      end
   end

   // Holds the flag back one cycle behind the response words.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         resp_ready <= 1'b0;
      end else begin
         resp_ready <= (cstate == PLH_C_RUN) && !resp_ready &&
                       (job_action == PLH_ACT_NONE || job_done);   // [R8]
      end
   end

   // Response words are loaded at least one cycle before the flag rises.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         resp_command_code    <= 16'h0;
         resp_command_subcode <= 16'h0;
         result_code          <= 16'h0;
         result_payload       <= 32'h0;
      end else if (cstate == PLH_C_IDLE && execute_request) begin
         resp_command_code    <= command_code;                     // [R3]
         resp_command_subcode <= command_subcode;
         result_code    <= (next_action == PLH_ACT_NONE) ? `PLH_RESP_CODE_BAD : `PLH_RESP_CODE_OK;
         result_payload <= `PLH_RESULT_NG;
      end else if (cstate == PLH_C_RUN && job_action != PLH_ACT_NONE && job_done) begin
         result_payload <= job_ok ? `PLH_RESULT_OK : `PLH_RESULT_NG; // [R3] [R8]
      end
   end

   // -----------------------------------------------------------------
   // Data output handshake
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      PLH_O_WAIT,
      PLH_O_STROBE,
      PLH_O_DROP
   } plh_out_state_t;

   plh_out_state_t ostate;
   logic [DATA_W-1:0] buf_data;
   logic              buf_valid;
   logic              buf_ready;
   logic              flush;
   logic              out_tmo;

   plh_skid2 #(.WIDTH(DATA_W)) u_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .flush     (flush),
      .in_valid  (meas_valid),
      .in_ready  (meas_ready),
      .in_data   (format_float ? meas_float : meas_fixed),         // [R19]
      .out_valid (buf_valid),
      .out_ready (buf_ready),
      .out_data  (buf_data)
   );

   plh_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_out_timer (
      .clk      (clk),
      .rst_n    (rst_n),
      .run      ((ostate == PLH_O_WAIT && buf_valid && !output_request) ||
                 ostate == PLH_O_STROBE),
      .limit_ms (retry_ms),
      .expired  (out_tmo)
   );

   assign buf_ready = (ostate == PLH_O_WAIT) && buf_valid && output_request;
   assign flush     = (ostate == PLH_O_WAIT) && buf_valid && !output_request && out_tmo; // [R16]

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ostate        <= PLH_O_WAIT;
         output_strobe <= 1'b0;
         output_data   <= {DATA_W{1'b0}};
      end else begin
         case (ostate)
            PLH_O_WAIT: begin
               if (buf_ready) begin
                  output_data <= buf_data;                         // [R13]
                  ostate      <= PLH_O_STROBE;
               end
            end
            PLH_O_STROBE: begin
               output_strobe <= 1'b1;                              // [R13]
               if (output_strobe && (!output_request || out_tmo)) begin
                  output_strobe <= 1'b0;                           // [R15] [R17]
                  ostate <= output_request ? PLH_O_DROP : PLH_O_WAIT;
               end
            end
            PLH_O_DROP: begin
               if (!output_request) ostate <= PLH_O_WAIT;
            end
            default: ostate <= PLH_O_WAIT;
         endcase
      end
   end

   // Overtime: the host let a handshake time out; the event wins over clear.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         overtime_error <= 1'b0;
      end else if ((cstate == PLH_C_DONE && cmd_tmo) || flush ||
                   (ostate == PLH_O_STROBE && output_strobe && out_tmo)) begin
         overtime_error <= 1'b1;                                   // [R18]
      end else if (error_clear) begin
         overtime_error <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   chk_flag_needs_busy: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
      completion_flag |-> busy)
      else $error("Completion flag high without busy.");

   chk_exec_sets_busy: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
      (cstate == PLH_C_IDLE && execute_request) |=> busy)
      else $error("Busy did not rise on execute request.");

   chk_drop_clears_flag: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
      (completion_flag && !execute_request) |=> (!completion_flag && !busy))
      else $error("Flag or busy stayed high after request dropped.");

   chk_retry_forces_low: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
      (cstate == PLH_C_DONE && cmd_tmo) |=> !completion_flag)
      else $error("Retry timeout did not clear completion flag.");

   chk_hold_no_rearm: assert property (@(posedge clk) disable iff (!rst_n) // [R20]
      (cstate == PLH_C_HOLD) |=> !busy)
      else $error("Held execute request restarted a command.");

   chk_result_value: assert property (@(posedge clk) disable iff (!rst_n) // [R3] [R8]
      $rose(completion_flag) |-> ($stable(result_payload) &&
                                  (result_payload == `PLH_RESULT_OK ||
                                   result_payload == `PLH_RESULT_NG)))
      else $error("Result payload not settled or not valid.");

   chk_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
      (cstate == PLH_C_IDLE) |-> (!busy && !completion_flag))
      else $error("Busy or flag high while idle.");

   chk_words_settled: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
      $rose(completion_flag) |-> ($stable(result_code) && $stable(resp_command_code) &&
                                  $stable(resp_command_subcode)))
      else $error("Response words moved as the flag rose.");

   chk_start_pulse: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
      job_start |=> !job_start)
      else $error("Job start longer than a cycle.");

   chk_save_action: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
      (cstate == PLH_C_IDLE && execute_request && known &&
       command_code == `PLH_CMD_SAVE_ALL) |=> (job_start && job_action == PLH_ACT_SAVE_ALL))
      else $error("Save command started no save job.");

   chk_default_capture: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
      (cstate == PLH_C_IDLE && execute_request && known && command_argument == 32'h0 &&
       command_code == `PLH_CMD_SCREEN_CAP) |=> (job_action == PLH_ACT_CAPTURE_DEFAULT))
      else $error("Empty argument missed default capture.");

   chk_bmp_suffix: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
      (cstate == PLH_C_IDLE && execute_request && known && command_argument != 32'h0 &&
       command_code == `PLH_CMD_SCREEN_CAP) |=>
         (job_action == PLH_ACT_CAPTURE &&
          job_append_bmp == ($past(command_argument) != `PLH_EXT_BMP)))
      else $error("Capture suffix choice wrong.");

   chk_flush_empties: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
      flush |=> !buf_valid)
      else $error("Discarded data still waiting.");

   chk_tmo_drops_strobe: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
      (ostate == PLH_O_STROBE && output_strobe && out_tmo) |=> !output_strobe)
      else $error("Held request did not end the strobe.");

   chk_strobe_in_state: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
      output_strobe |-> (ostate == PLH_O_STROBE))
      else $error("Strobe high outside its state.");

   chk_error_sticky: assert property (@(posedge clk) disable iff (!rst_n) // [R18]
      (overtime_error && !error_clear) |=> overtime_error)
      else $error("Overtime error dropped unasked.");

   chk_strobe_after_data: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
      buf_ready |=> (output_data == $past(buf_data)) ##1 output_strobe)
      else $error("Strobe did not follow presented data.");

   chk_strobe_clears: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
      (output_strobe && !output_request) |=> !output_strobe)
      else $error("Strobe stayed high after output request dropped.");

   chk_overtime_flag: assert property (@(posedge clk) disable iff (!rst_n) // [R18]
      flush |=> overtime_error)
      else $error("Discarded data did not raise overtime error.");
endmodule
`default_nettype wire

// file: verilog/plh_defs.svh
/*
 * Constants for the link command and data output handshake block.
 * Assumes a 50 MHz clock and a 16-bit word link to the controller.
 */
`ifndef PLH_DEFS_SVH
`define PLH_DEFS_SVH

`define PLH_CMD_SAVE_ALL     16'h5000
`define PLH_CMD_SCREEN_CAP   16'h6010
`define PLH_CMD_SUBCODE      16'h0070
`define PLH_RESULT_OK        32'h0000_0000
`define PLH_RESULT_NG        32'hffff_ffff
`define PLH_RESP_CODE_OK     16'h0000
`define PLH_RESP_CODE_BAD    16'h0001
`define PLH_PATH_MAX_CHARS   256
`define PLH_CLK_HZ           50000000
`define PLH_CYC_PER_MS       (`PLH_CLK_HZ / 1000)
`define PLH_RETRY_MS_MAX     999999
`define PLH_EXT_BMP          32'h2e62_6d70

`endif

// file: verilog/plh_pkg.sv
/*
 * Types shared by the handshake block.
 * Assumes the constants header is available on the include path.
 */
package plh_pkg;
   typedef enum logic [1:0] {
      PLH_ACT_NONE,
      PLH_ACT_SAVE_ALL,
      PLH_ACT_CAPTURE,
      PLH_ACT_CAPTURE_DEFAULT
   } plh_action_t;
   typedef enum logic [0:0] {
      PLH_FMT_FIXED,
      PLH_FMT_FLOAT
   } plh_format_t;
endpackage

// file: verilog/plh_ms_timer.sv
/*
 * Millisecond timeout counter, restarted whenever run is low.
 * Assumes a synchronous active-low reset and a 50 MHz clock.
 */
`timescale 1ns/1ps
`include "plh_defs.svh"
`default_nettype none
module plh_ms_timer #(
   parameter int CYC_PER_MS = `PLH_CYC_PER_MS
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        run,
   input  wire logic [19:0] limit_ms,
   output logic             expired
);
   logic [31:0] cyc;
   logic [19:0] ms;

   initial begin
      if (CYC_PER_MS < 1) $error("CYC_PER_MS must be at least one.");
   end

   // Counts whole milliseconds while run stays high.
   always_ff @(posedge clk) begin
      if (!rst_n || !run) begin
         cyc <= 32'h0;
         ms  <= 20'h0;
      end else if (!expired) begin
         if (cyc == 32'(CYC_PER_MS - 1)) begin
            cyc <= 32'h0;
            ms  <= ms + 20'h1;
         end else begin
            cyc <= cyc + 32'h1;
         end
      end
   end

   assign expired = run && (ms >= limit_ms);
endmodule
`default_nettype wire

// file: verilog/plh_skid2.sv
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module plh_skid2 #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   logic [WIDTH-1:0] mem [2];
   logic             wr_ptr;
   logic             rd_ptr;
   logic [1:0]       count;
   logic             push;
   logic             pop;

   initial begin
      if (WIDTH < 1) $error("WIDTH must be at least one.");
   end

   assign in_ready  = (count != 2'h2) && !flush;
   assign out_valid = (count != 2'h0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || flush) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (push) wr_ptr <= !wr_ptr;
         if (pop) rd_ptr <= !rd_ptr;
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule
`default_nettype wire

// file: verif/plh_host_model.sv
/*
 * Controller model: loads the command words and raises the execute and output
 * requests, waiting at rising edges for each answer up to its wait limit (400 or 40 cycles); execute then drops only when asked, output after hold further cycles.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/1ps
`include "plh_defs.svh"
`default_nettype none
module plh_host_model (
   input  wire logic        clk,
   output logic [15:0]      command_code,
   output logic [15:0]      command_subcode,
   output logic [31:0]      command_argument,
   output logic             execute_request,
   output logic             output_request,
   input  wire logic        completion_flag,
   input  wire logic        output_strobe,
   input  wire logic [31:0] output_data
);
   // ----------------------------------------------------------------
   // Request drivers
   // ----------------------------------------------------------------
   initial begin
      command_code = 16'h0000;
      command_subcode = 16'h0000;
      command_argument = 32'h0000_0000;
      execute_request = 1'b0;
      output_request = 1'b0;
   end

   task automatic command(input logic [15:0] c, input logic [31:0] a, input bit drop,
                          output bit ok);
      int n;
      command_code <= c;
      command_subcode <= `PLH_CMD_SUBCODE;
      command_argument <= a;
      @(posedge clk);
      execute_request <= 1'b1;
      n = 0;
      while (completion_flag !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      ok = (n < 400);
      if (drop) execute_request <= 1'b0;
   endtask

   task automatic fetch(input int hold, output logic [31:0] d, output bit ok,
                        output logic s);
      int n;
      output_request <= 1'b1;
      n = 0;
      while (output_strobe !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      ok = (n < 40);
      d = output_data;
      repeat (hold) @(posedge clk);
      s = output_strobe;
      output_request <= 1'b0;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
/*
 * Self-checking bench for the link handshake block with a queue model.
 * Assumes the design, its package and its header are compiled first.
 */
`timescale 1ns/1ps
`include "plh_defs.svh"
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin bad_count++; \
$display("wrong value %s expected %h seen %h", n, e, a); end end
module tb;
   import plh_pkg::*;
   logic        clk, rst_n, execute_request, output_request, busy, completion_flag;
   logic [15:0] command_code, command_subcode, resp_command_code, resp_command_subcode;
   logic [15:0] result_code;
   logic [31:0] command_argument, result_payload, meas_fixed, meas_float, output_data;
   logic [31:0] d, e, a;
   logic [19:0] retry_ms;
   logic        job_append_bmp, job_start, job_ok, format_float, meas_valid, meas_ready;
   logic        output_strobe, overtime_error, error_clear, s, bmp_seen;
   logic        job_done = 1'b0;
   plh_action_t job_action, act_seen;
   int          bad_count = 0, check_count = 0, seed = 32'h90f0, jcnt = 0, starts = 0;
   int          job_lat = 1, n, n0;
   bit          ok, taken;
   logic [31:0] exp_q[$];
   logic [15:0] codes [6] = '{`PLH_CMD_SAVE_ALL, `PLH_CMD_SAVE_ALL, `PLH_CMD_SCREEN_CAP,
                              `PLH_CMD_SCREEN_CAP, `PLH_CMD_SCREEN_CAP, 16'h4010};
   logic [31:0] args [6] = '{32'h0, 32'h0, `PLH_EXT_BMP, 32'h2e6a_7067, 32'h0, 32'h1};

   plh_link_handshake #(.CYC_PER_MS(2), .DATA_W(32)) uut (
      .clk(clk), .rst_n(rst_n), .command_code(command_code),
      .command_subcode(command_subcode), .command_argument(command_argument),
      .execute_request(execute_request), .busy(busy), .completion_flag(completion_flag),
      .resp_command_code(resp_command_code), .resp_command_subcode(resp_command_subcode),
      .result_code(result_code), .result_payload(result_payload),
      .job_action(job_action), .job_append_bmp(job_append_bmp), .job_start(job_start),
      .job_done(job_done), .job_ok(job_ok), .retry_ms(retry_ms),
      .format_float(format_float), .meas_valid(meas_valid), .meas_ready(meas_ready),
      .meas_fixed(meas_fixed), .meas_float(meas_float), .output_request(output_request),
      .output_strobe(output_strobe), .output_data(output_data),
      .overtime_error(overtime_error), .error_clear(error_clear));

   plh_host_model host (
      .clk(clk), .command_code(command_code), .command_subcode(command_subcode),
      .command_argument(command_argument), .execute_request(execute_request),
      .output_request(output_request), .completion_flag(completion_flag),
      .output_strobe(output_strobe), .output_data(output_data));

   // ----------------------------------------------------------------
   // Clock, job engine and run limit
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      job_done <= 1'b0;
      if (job_start === 1'b1) begin
         jcnt <= job_lat;
         starts <= starts + 1;
         act_seen <= job_action;
         bmp_seen <= job_append_bmp;
      end else if (jcnt == 1) begin
         jcnt <= 0;
         job_done <= 1'b1;
      end else if (jcnt > 1) begin
         jcnt <= jcnt - 1;
      end
   end

   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      print_verdict();
   end

   task automatic print_verdict;
      if (bad_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic need(input bit good);
      if (!good) begin
         bad_count++;
         print_verdict();
      end
   endtask

   task automatic wait_idle(input bit outp);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((outp ? output_strobe : busy | completion_flag) !== 1'b0 && n < 5);
      `CHK("idle", 1'b0, outp ? output_strobe : busy | completion_flag)
   endtask

   task automatic push;
      logic [31:0] x, f;
      x = $random(seed);
      f = $random(seed);
      meas_fixed <= x;
      meas_float <= f;
      meas_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (meas_ready !== 1'b1 && n < 4);
      taken = (meas_ready === 1'b1);
      if (taken) exp_q.push_back(format_float ? f : x);
      meas_valid <= 1'b0;
      @(posedge clk);
   endtask

   task automatic run_cmd(input logic [15:0] c, input logic [31:0] arg, input bit good);
      bit known;
      known = (c == `PLH_CMD_SAVE_ALL) || (c == `PLH_CMD_SCREEN_CAP);
      n0 = starts;
      host.command(c, arg, 1'b1, ok);
      need(ok);
      `CHK("busy", 1'b1, busy)
      `CHK("echo code", c, resp_command_code)
      `CHK("echo sub", `PLH_CMD_SUBCODE, resp_command_subcode)
      `CHK("result code", known ? 16'h0000 : 16'h0001, result_code)
      `CHK("payload", known && good ? `PLH_RESULT_OK : `PLH_RESULT_NG, result_payload)
      `CHK("starts", n0 + known, starts)
      if (c == `PLH_CMD_SAVE_ALL) `CHK("action", PLH_ACT_SAVE_ALL, act_seen)
      if (c == `PLH_CMD_SCREEN_CAP) begin
         `CHK("action", arg == 0 ? PLH_ACT_CAPTURE_DEFAULT : PLH_ACT_CAPTURE, act_seen)
         if (arg != 0) `CHK("bmp", arg != `PLH_EXT_BMP, bmp_seen)
      end
      wait_idle(1'b0);
   endtask

   task automatic clr_err;
      error_clear <= 1'b1;
      @(posedge clk);
      error_clear <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK("error cleared", 1'b0, overtime_error)
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      retry_ms = 20'd1000;
      format_float = 1'b0;
      meas_valid = 1'b0;
      meas_fixed = 32'h0;
      meas_float = 32'h0;
      job_ok = 1'b0;
      error_clear = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         a = (i < 2) ? $random(seed) : args[i];
         job_ok <= (i != 1);
         job_lat = 1 + ($random(seed) & 7);
         run_cmd(codes[i], a, i != 1);
      end
      retry_ms <= 20'd3;
      job_lat = 2;
      n0 = starts;
      host.command(`PLH_CMD_SAVE_ALL, 32'h0, 1'b0, ok);
      need(ok);
      repeat (16) @(posedge clk);
      `CHK("forced idle", 1'b0, busy | completion_flag)
      `CHK("no restart", n0 + 1, starts)
      `CHK("cmd overtime", 1'b1, overtime_error)
      host.execute_request <= 1'b0;
      clr_err();
      retry_ms <= 20'd1000;
      for (int k = 0; k < 2; k++) begin
         format_float <= k[0];
         @(posedge clk);
         n0 = 0;
         do begin
            push();
            n0++;
         end while (taken && n0 < 5);
         `CHK("fill depth", 3, n0)
         while (exp_q.size() > 0) begin
            host.fetch($random(seed) & 3, d, ok, s);
            need(ok);
            e = exp_q.pop_front();
            `CHK("data", e, d)
            `CHK("strobe held", 1'b1, s)
            wait_idle(1'b1);
         end
         host.fetch(0, d, ok, s);
         `CHK("empty", 1'b0, ok)
      end
      retry_ms <= 20'd3;
      push();
      repeat (16) @(posedge clk);
      `CHK("unrequested", 1'b1, overtime_error)
      exp_q.delete();
      host.fetch(0, d, ok, s);
      `CHK("discarded", 1'b0, ok)
      clr_err();
      push();
      host.fetch(16, d, ok, s);
      need(ok);
      e = exp_q.pop_front();
      `CHK("data", e, d)
      `CHK("forced strobe", 1'b0, s)
      `CHK("held overtime", 1'b1, overtime_error)
      clr_err();
      print_verdict();
   end
endmodule
`default_nettype wire
